// *** rtl/bpc_host.sv ***
// Purpose: Host-side enable and data controller for a polarity-correcting bus transceiver.
// Assumes: All inputs synchronous to mclk; one clock domain.
// Notes:   Long counts are parameters so simulation can shorten them.
`default_nettype none
module bpc_host #(
    parameter int unsigned IDLE_HOLD_CYC = bpc_pkg::IDLE_HOLD_CYC,
    parameter int unsigned RUN_MAX_CYC   = bpc_pkg::RUN_MAX_CYC
) (
    input  wire logic mclk,
    input  wire logic srst,
    input  wire logic tx_req,
    input  wire logic tx_bit,
    input  wire logic tx_last,
    input  wire logic sleep_req,
    input  wire logic rx_pin,
    output logic      tx_ack,
    output logic      rx_data,
    output logic      ready,
    output logic      run_err,
    output logic      tx_pin,
    output logic      driver_enable,
    output logic      receiver_enable_n
);
    localparam int unsigned CW = bpc_pkg::CNT_W;

    bpc_pkg::bpc_state_e state_reg;
    bpc_pkg::bpc_state_e state_next;
    logic [CW-1:0]       idle_cnt_reg;
    logic [CW-1:0]       run_cnt_reg;
    logic                last_bit_reg;
    logic                rx_prev_reg;
    logic                tx_ack_reg;
    logic                run_err_reg;
    logic                last_take_reg;

    // Bus-side decodes, shared by the pin registers and the handshake logic.
    function automatic logic drives_bus(input bpc_pkg::bpc_state_e s);
        return s == bpc_pkg::BPC_TX;
    endfunction

    function automatic logic powers_down(input bpc_pkg::bpc_state_e s);
        return s == bpc_pkg::BPC_STANDBY;
    endfunction

    wire logic idle_done = (idle_cnt_reg >= CW'(IDLE_HOLD_CYC));
    wire logic rx_edge   = (rx_pin != rx_prev_reg);
    wire logic take      = drives_bus(state_reg) && tx_req && !tx_ack_reg;
    wire logic same_bit  = (tx_bit == last_bit_reg);
    wire logic run_long  = take && same_bit && (run_cnt_reg >= CW'(RUN_MAX_CYC));
    wire logic drv_on    = drives_bus(state_reg);
    wire logic rcv_on_n  = powers_down(state_reg);

    // Idle restarts on any received change or on driving, so only a quiet bus counts.
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            bpc_pkg::BPC_IDLE_WAIT:
                if (idle_done)
                    state_next = bpc_pkg::BPC_READY;
            bpc_pkg::BPC_READY:
                if (sleep_req)
                    state_next = bpc_pkg::BPC_STANDBY;
                else if (tx_req)
                    state_next = bpc_pkg::BPC_TX;
            bpc_pkg::BPC_TX:
                // Leave one cycle after the final take, so the last bit is driven too.
                if (last_take_reg)
                    state_next = bpc_pkg::BPC_READY;
            bpc_pkg::BPC_STANDBY:
                if (!sleep_req)
                    state_next = bpc_pkg::BPC_READY;
            default:
                state_next = bpc_pkg::BPC_IDLE_WAIT;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            state_reg    <= bpc_pkg::BPC_IDLE_WAIT;
            idle_cnt_reg <= '0;
            run_cnt_reg  <= '0;
            last_bit_reg <= 1'b1;
            // Follow the pin in reset, so release shows no false bus edge.
            rx_prev_reg  <= rx_pin;
            tx_ack_reg   <= 1'b0;
            run_err_reg  <= 1'b0;
            last_take_reg <= 1'b0;
        end
        else
        begin
            state_reg   <= state_next;
            rx_prev_reg <= rx_pin;
            if (state_reg != bpc_pkg::BPC_IDLE_WAIT || rx_edge)
                idle_cnt_reg <= '0;
            else if (!idle_done)
                idle_cnt_reg <= idle_cnt_reg + CW'(1);
            tx_ack_reg    <= take;
            last_take_reg <= take && tx_last;
            if (take)
            begin
                last_bit_reg <= tx_bit;
                // Counted per accepted bit; a bit period is one request here.
                // A changed bit opens a run that already holds one bit.
                run_cnt_reg  <= same_bit ? run_cnt_reg + CW'(1) : CW'(1);
            end
            run_err_reg <= run_long;
        end
    end

    // Outputs from flip-flops: register the pin levels.
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            driver_enable     <= 1'b0;
            receiver_enable_n <= 1'b0;
            tx_pin            <= 1'b1;
            rx_data           <= 1'b1;
            ready             <= 1'b0;
        end
        else
        begin
            driver_enable     <= drives_bus(state_next);
            receiver_enable_n <= powers_down(state_next);
            tx_pin            <= take ? tx_bit : tx_pin;
            rx_data           <= rx_pin; // correction lives in the far end.
            ready             <= (state_next == bpc_pkg::BPC_READY);
        end
    end

    assign tx_ack  = tx_ack_reg;
    assign run_err = run_err_reg;

    // Standby glitch span: count cycles with both enables off.
    logic [CW-1:0] off_cnt;
    always_ff @(posedge mclk)
    begin
        if (srst)
            off_cnt <= '0;
        else if (!driver_enable && receiver_enable_n)
            off_cnt <= off_cnt + CW'(1);
        else
            off_cnt <= '0;
    end

    no_drive_idle_a: assert property (@(posedge mclk) disable iff (srst)
        (state_reg == bpc_pkg::BPC_IDLE_WAIT) |-> (!driver_enable && !receiver_enable_n))
        else $error("Enables not idle during failsafe wait.");

    idle_hold_a: assert property (@(posedge mclk) disable iff (srst)
        $rose(ready) && $past(state_reg) == bpc_pkg::BPC_IDLE_WAIT
        |-> $past(idle_cnt_reg) >= CW'(IDLE_HOLD_CYC))
        else $error("Left idle wait before the hold time.");

    idle_restart_a: assert property (@(posedge mclk) disable iff (srst)
        (state_reg == bpc_pkg::BPC_IDLE_WAIT && rx_edge) |=> idle_cnt_reg == '0)
        else $error("Idle count not restarted on bus change.");

    drv_pair_a: assert property (@(posedge mclk) disable iff (srst)
        driver_enable |-> !receiver_enable_n)
        else $error("Driver on while receiver off.");

    stby_exit_a: assert property (@(posedge mclk) disable iff (srst)
        (state_reg == bpc_pkg::BPC_STANDBY && !sleep_req) |=> !receiver_enable_n)
        else $error("Standby not left on wake.");

    run_flag_a: assert property (@(posedge mclk) disable iff (srst)
        run_long |=> run_err)
        else $error("Long run not flagged.");

    ack_pulse_a: assert property (@(posedge mclk) disable iff (srst)
        tx_ack |-> $past(state_reg) == bpc_pkg::BPC_TX ##1 !tx_ack)
        else $error("Acknowledge outside transmit.");

    // Both enables may be off only in standby, never briefly while switching direction.
    stby_glitch_a: assert property (@(posedge mclk) disable iff (srst)
        (!driver_enable && receiver_enable_n) |-> rcv_on_n)
        else $error("Both enables off outside standby.");

    drv_state_a: assert property (@(posedge mclk) disable iff (srst)
        driver_enable == drv_on)
        else $error("Driver enable does not follow transmit state.");

    reset_quiet_a: assert property (@(posedge mclk) disable iff (srst)
        $past(srst) |-> (!driver_enable && !receiver_enable_n))
        else $error("Direction not held low after reset.");

    first_tx_a: assert property (@(posedge mclk) disable iff (srst)
        $rose(driver_enable) |-> $past(state_reg) == bpc_pkg::BPC_READY)
        else $error("Driver enabled without passing the idle hold.");

    ready_idle_a: assert property (@(posedge mclk) disable iff (srst)
        ready |-> (!driver_enable && !receiver_enable_n))
        else $error("Enables not idle while ready.");

    frame_end_a: assert property (@(posedge mclk) disable iff (srst)
        (take && tx_last) |=> driver_enable ##1 (ready && !driver_enable))
        else $error("Final bit not driven or bus not released.");

    run_restart_a: assert property (@(posedge mclk) disable iff (srst)
        (take && !same_bit) |=> run_cnt_reg == CW'(1))
        else $error("Run length not restarted on a changed bit.");

    sleep_entry_a: assert property (@(posedge mclk) disable iff (srst)
        (state_reg == bpc_pkg::BPC_READY && sleep_req) |=> (receiver_enable_n && !driver_enable))
        else $error("Sleep request did not turn both enables off.");

    tx_hold_a: assert property (@(posedge mclk) disable iff (srst)
        !take |=> $stable(tx_pin))
        else $error("Transmit data changed without a take.");

    c_tx_c: cover property (@(posedge mclk) disable iff (srst) tx_ack && tx_last);
    c_stby_c: cover property (@(posedge mclk) disable iff (srst) $fell(receiver_enable_n));
    c_ready_c: cover property (@(posedge mclk) disable iff (srst) $rose(ready));
    c_err_c: cover property (@(posedge mclk) disable iff (srst) run_err);
    c_deep_c: cover property (@(posedge mclk) disable iff (srst)
        off_cnt == CW'(bpc_pkg::STBY_CYC));
endmodule // bpc_host
`default_nettype wire

// *** rtl/bpc_pkg.sv ***
// Purpose: Shared constants for the transceiver host controller.
// Assumes: mclk at 40 MHz.
// Notes:   Times are kept in their own unit and converted to cycles here.
`default_nettype none
package bpc_pkg;
    localparam int unsigned CLK_MHZ        = 40;
    localparam int unsigned STBY_MIN_NS    = 300;
    localparam int unsigned GLITCH_MAX_NS  = 100;
    localparam int unsigned FS_MIN_MS      = 44;
    localparam int unsigned FS_TYP_MS      = 58;
    localparam int unsigned FS_MAX_MS      = 76;
    localparam int unsigned FS_MARGIN_MS   = 4;
    // Least times round up.
    localparam int unsigned STBY_CYC = (STBY_MIN_NS * CLK_MHZ + 999) / 1000;
    // Longest time rounds down.
    localparam int unsigned GLITCH_CYC = (GLITCH_MAX_NS * CLK_MHZ) / 1000;
    // Idle hold before first transmit must exceed the largest far-end failsafe time.
    localparam int unsigned IDLE_HOLD_CYC = (FS_MAX_MS + FS_MARGIN_MS) * 1000 * CLK_MHZ;
    // A steady run of one level must stay below the least failsafe time.
    localparam int unsigned RUN_MAX_CYC = (FS_MIN_MS * 1000 * CLK_MHZ) - 1;
    localparam int unsigned CNT_W = 32;
    typedef enum logic [1:0] {BPC_IDLE_WAIT, BPC_READY, BPC_TX, BPC_STANDBY} bpc_state_e;
endpackage : bpc_pkg
`default_nettype wire

// *** bench/bpc_xcvr_model.sv ***
// Purpose: Behavioural transceiver with standby and polarity correction.
// Assumes: Failsafe time shortened to FS_CYC cycles of mclk.
// Notes:   A released receive output toggles, so stale data never passes.
`default_nettype none
module bpc_xcvr_model #(
    parameter int unsigned FS_CYC = 30
) (
    input  wire logic mclk,
    input  wire logic pwr_rst,
    input  wire logic tx_pin,
    input  wire logic driver_enable,
    input  wire logic receiver_enable_n,
    input  wire logic bus_line,
    output logic      rx_pin,
    output logic      bus_out,
    output logic      standby
);
    timeunit 1ns;
    timeprecision 1ps;
    int unsigned off_cnt;
    int unsigned idle_cnt;
    logic        pol_fix;
    logic        last_bus;
    logic        toggle = 1'b0;
    always @(posedge mclk)
    begin
        toggle <= ~toggle;
        last_bus <= bus_line;
        if (pwr_rst)
        begin
            pol_fix  <= 1'b0;
            idle_cnt <= 0;
            off_cnt  <= 0;
            standby  <= 1'b0;
        end
        else
        begin
            idle_cnt <= (bus_line !== last_bus || driver_enable) ? 0 : idle_cnt + 1;
            if (idle_cnt >= FS_CYC && !bus_line && !driver_enable)
                pol_fix <= 1'b1;
            off_cnt <= (!driver_enable && receiver_enable_n) ? off_cnt + 1 : 0;
            standby <= !driver_enable && receiver_enable_n
                && off_cnt >= bpc_pkg::STBY_CYC - 1;
        end
    end
    assign rx_pin  = receiver_enable_n ? toggle : bus_line ^ pol_fix;
    assign bus_out = driver_enable ? tx_pin ^ pol_fix : bus_line;
endmodule // bpc_xcvr_model
`default_nettype wire

// *** bench/bus_polarity_corrector_tb.sv ***
// Purpose: Self-checking bench for the transceiver host controller.
// Assumes: Idle hold of 50 cycles and run limit of 5 bits.
// Notes:   The bus idles low, so the model always ends up correcting.
`default_nettype none
module bus_polarity_corrector_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0, srst = 1'b1, tx_req = 1'b0, tx_bit = 1'b0, tx_last = 1'b0;
    logic sleep_req = 1'b0, bus_line = 1'b0, rx_pin, bus_out, standby;
    logic tx_ack, rx_data, ready, run_err, tx_pin, driver_enable, receiver_enable_n;
    logic [7:0] b;
    int   mismatches = 0, n_checks = 0, err_seen = 0, seed = 36546, n;
    bpc_host #(.IDLE_HOLD_CYC(50), .RUN_MAX_CYC(5)) dut (.mclk(mclk), .srst(srst),
        .tx_req(tx_req), .tx_bit(tx_bit), .tx_last(tx_last), .sleep_req(sleep_req),
        .rx_pin(rx_pin), .tx_ack(tx_ack), .rx_data(rx_data), .ready(ready),
        .run_err(run_err), .tx_pin(tx_pin), .driver_enable(driver_enable),
        .receiver_enable_n(receiver_enable_n));
    bpc_xcvr_model #(.FS_CYC(30)) xcvr (.mclk(mclk), .pwr_rst(srst), .tx_pin(tx_pin),
        .driver_enable(driver_enable), .receiver_enable_n(receiver_enable_n),
        .bus_line(bus_line), .rx_pin(rx_pin), .bus_out(bus_out), .standby(standby));
    initial forever #12.5 mclk = ~mclk;
    always @(posedge mclk) if (run_err === 1'b1) err_seen++;
    task automatic check(input logic seen, input logic exp);
        n_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: saw %b want %b", $time, seen, exp);
        end
    endtask
    task automatic stop_test;
        $display("mismatches %0d checks %0d", mismatches, n_checks);
        if (mismatches == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Always passes one edge first, so a pulse seen at the last edge is not taken twice.
    task automatic wait_hi(ref logic s, input int lim);
        n = 0;
        do
        begin
            @(posedge mclk);
            n++;
            if (n > lim)
            begin
                mismatches++;
                stop_test();
            end
        end
        while (s !== 1'b1);
    endtask
    task automatic send(input logic [7:0] bits, input int len);
        for (int i = 0; i < len; i++)
        begin
            tx_req  <= 1'b1;
            tx_bit  <= bits[i];
            tx_last <= (i == len - 1);
            wait_hi(tx_ack, 20);
            check(tx_pin, bits[i]);
            check(bus_out, ~bits[i]);
        end
        tx_req  <= 1'b0;
        tx_last <= 1'b0;
        wait_hi(ready, 20);
    endtask
    initial
    begin
        repeat (3) @(posedge mclk);
        check(driver_enable, 1'b0);
        check(receiver_enable_n, 1'b0);
        repeat (3) @(posedge mclk);
        srst <= 1'b0;
        wait_hi(ready, 500);
        check(n >= 52, 1'b1);
        b = 8'($random(seed));
        b[2] = ~b[1];
        b[5] = ~b[4];
        send(b, 8);
        check(err_seen == 0, 1'b1);
        send(8'h00, 6);
        check(err_seen > 0, 1'b1);
        sleep_req <= 1'b1;
        wait_hi(standby, 40);
        check(driver_enable, 1'b0);
        check(receiver_enable_n, 1'b1);
        sleep_req <= 1'b0;
        wait_hi(ready, 500);
        @(posedge mclk);
        check(standby, 1'b0);
        check(receiver_enable_n, 1'b0);
        repeat (4)
        begin
            b[0] = 1'($random(seed));
            bus_line <= b[0];
            repeat (2) @(posedge mclk);
            check(rx_data, ~b[0]);
        end
        stop_test();
    end
endmodule // bus_polarity_corrector_tb
`default_nettype wire
